// ==== hw/sdram_cmd_pkg.sv ====
// shared constants and types for the sdram command link
package sdram_cmd_pkg;
  localparam int ROW_W      = 13;
  localparam int COL_W      = 9;
  localparam int BANK_W     = 2;
  localparam int NUM_BANKS  = 4;
  localparam int DATA_W     = 16;
  localparam int PRE_BIT    = 10;
  localparam int RD_MASK_LAT = 2;
  localparam int MEM_DEPTH  = 64;
  localparam int MEM_AW     = 6;

  // command strobes {row, col, write}, active low
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_MRS  = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_NOP  = 3'h7;

  typedef enum logic [2:0] {
    OP_NONE, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_MRS, OP_REF
  } op_type;

  typedef enum {
    DEV_RUN, DEV_POWER_DOWN, DEV_SELF_REFRESH
  } dev_state_type;
endpackage

// ==== hw/sdram_link_if.sv ====
// pin-level link between controller and memory device
`timescale 1ns/1ns
interface sdram_link_if;
  logic                                select_n;
  logic                                row_strobe_n;
  logic                                col_strobe_n;
  logic                                write_strobe_n;
  logic                                clock_gate_in;
  logic [sdram_cmd_pkg::BANK_W-1:0]    bank_sel;
  logic [sdram_cmd_pkg::ROW_W-1:0]     addr;
  logic                                lower_byte_mask;
  logic                                upper_byte_mask;
  logic [sdram_cmd_pkg::DATA_W-1:0]    data_ctl_out;
  logic                                data_ctl_oe;
  logic [sdram_cmd_pkg::DATA_W-1:0]    data_dev_out;
  logic [1:0]                          data_dev_oe;
  logic [sdram_cmd_pkg::DATA_W-1:0]    data_lines;

  // resolved bus level per byte lane
  always_comb begin
    data_lines = data_ctl_oe ? data_ctl_out : 16'h0000;
    if (data_dev_oe[0]) begin
      data_lines[7:0] = data_dev_out[7:0];
    end
    if (data_dev_oe[1]) begin
      data_lines[15:8] = data_dev_out[15:8];
    end
  end

  modport device (
    input  select_n, row_strobe_n, col_strobe_n, write_strobe_n,
    input  clock_gate_in, bank_sel, addr,
    input  lower_byte_mask, upper_byte_mask, data_lines,
    output data_dev_out, data_dev_oe
  );
  modport ctrl (
    output select_n, row_strobe_n, col_strobe_n, write_strobe_n,
    output clock_gate_in, bank_sel, addr,
    output lower_byte_mask, upper_byte_mask, data_ctl_out, data_ctl_oe,
    input  data_lines
  );
endinterface

// ==== hw/sdram_cmd_decode.sv ====
// decodes one sampled command edge into an operation
`timescale 1ns/1ns
module sdram_cmd_decode (
  input  wire logic                 select_n,
  input  wire logic                 row_strobe_n,
  input  wire logic                 col_strobe_n,
  input  wire logic                 write_strobe_n,
  input  wire logic                 gate_prev,
  input  wire logic                 gate_now,
  output sdram_cmd_pkg::op_type     op,
  output logic                      idle_code,
  output logic                      pd_entry,
  output logic                      sr_entry,
  output logic                      wake
);
  logic [2:0] code;

  always_comb begin
    code = {row_strobe_n, col_strobe_n, write_strobe_n};
    op = sdram_cmd_pkg::OP_NONE;
    // deselect or nop
    idle_code = select_n || (code == sdram_cmd_pkg::CMD_NOP);
    pd_entry = gate_prev && !gate_now && idle_code;
    sr_entry = gate_prev && !gate_now && !select_n
               && (code == sdram_cmd_pkg::CMD_REF);
    wake = !gate_prev && gate_now && idle_code;
    if (!select_n && gate_prev) begin
      case (code)
        sdram_cmd_pkg::CMD_ACT: op = sdram_cmd_pkg::OP_ACT;
        sdram_cmd_pkg::CMD_RD:  op = sdram_cmd_pkg::OP_READ;
        sdram_cmd_pkg::CMD_WR:  op = sdram_cmd_pkg::OP_WRITE;
        sdram_cmd_pkg::CMD_PRE: op = sdram_cmd_pkg::OP_PRE;
        sdram_cmd_pkg::CMD_MRS: op = sdram_cmd_pkg::OP_MRS;
        sdram_cmd_pkg::CMD_REF: begin
          if (gate_now) begin
            op = sdram_cmd_pkg::OP_REF;
          end
        end
        default: op = sdram_cmd_pkg::OP_NONE;
      endcase
    end
  end
endmodule

// ==== hw/sdram_device.sv ====
// memory device end: command decode, bank state, data path
// Summary of operation
// - sample every input on rising clock
// - low clock gate stops internal clocking; read pipeline still shifts in power down and self refresh
// - commands decoded only with select low
// - activate takes 13-bit row, bank_sel bank
// - read/write use nine low address bits
// - address bit 10 requests auto-precharge
// - precharge bit 10 high means all banks
// - read mask tristates byte two cycles later
// - write mask blocks byte immediately
// - activate encoding, only to idle bank
// - read/write encoding, only to active bank
// - precharge encoding, legal any state
// - mode load all low, only when idle
// - nop and deselect do nothing
// - auto refresh needs gate high twice
// - self refresh: refresh code, gate falls
// - self refresh exit: gate rises, idle code
// - power down: gate falls with idle code
// - power down exit: gate rises, idle code
// - previous gate level qualifies each command
// - no power down during a burst; device enters it even with a read in flight
`timescale 1ns/1ns
module sdram_device (
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  sdram_link_if.device                           link,
  output logic [3:0]                             bank_open,
  output logic [sdram_cmd_pkg::ROW_W-1:0]        mode_word,
  output logic [1:0]                             dev_mode
);
  localparam int N = sdram_cmd_pkg::NUM_BANKS;

  sdram_cmd_pkg::dev_state_type              state_r;
  sdram_cmd_pkg::op_type                     op;
  logic                                      gate_prev_r;
  logic                                      idle_code;
  logic                                      pd_entry;
  logic                                      sr_entry;
  logic                                      wake;
  logic                                      running;
  logic [N-1:0]                              open_r;
  logic [sdram_cmd_pkg::ROW_W-1:0]           row_r [N];
  logic [N-1:0]                              auto_pre_r;
  logic [sdram_cmd_pkg::ROW_W-1:0]           mode_r;
  logic [sdram_cmd_pkg::DATA_W-1:0]          mem [sdram_cmd_pkg::MEM_DEPTH];
  logic [sdram_cmd_pkg::MEM_AW-1:0]          waddr;
  logic [sdram_cmd_pkg::BANK_W-1:0]          bank;
  logic [sdram_cmd_pkg::COL_W-1:0]           col;
  logic                                      hit;
  logic [sdram_cmd_pkg::DATA_W-1:0]          rd_pipe_r [2];
  logic [1:0]                                rd_valid_r;
  logic [1:0]                                mask_pipe_r [2];
  logic [sdram_cmd_pkg::DATA_W-1:0]          dout_r;
  logic [1:0]                                oe_r;

  // storage index from bank and low column bits
  function automatic logic [sdram_cmd_pkg::MEM_AW-1:0] mem_index(
    input logic [sdram_cmd_pkg::BANK_W-1:0] b,
    input logic [sdram_cmd_pkg::COL_W-1:0]  c
  );
    mem_index = {b, c[3:0]};
  endfunction

  sdram_cmd_decode i_sdram_cmd_decode (
    .select_n       (link.select_n),
    .row_strobe_n   (link.row_strobe_n),
    .col_strobe_n   (link.col_strobe_n),
    .write_strobe_n (link.write_strobe_n),
    .gate_prev      (gate_prev_r),
    .gate_now       (link.clock_gate_in),
    .op             (op),
    .idle_code      (idle_code),
    .pd_entry       (pd_entry),
    .sr_entry       (sr_entry),
    .wake           (wake)
  );

  assign bank = link.bank_sel;
  assign col  = link.addr[sdram_cmd_pkg::COL_W-1:0];
  assign running = (state_r == sdram_cmd_pkg::DEV_RUN);
  assign hit = running && open_r[bank];

  // previous clock gate level
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gate_prev_r <= 1'b1;
    end else begin
      gate_prev_r <= link.clock_gate_in;
    end
  end

  // power state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= sdram_cmd_pkg::DEV_RUN;
    end else begin
      case (state_r)
        sdram_cmd_pkg::DEV_RUN: begin
          if (sr_entry && open_r == '0) begin
            state_r <= sdram_cmd_pkg::DEV_SELF_REFRESH;
          end else if (pd_entry) begin
            state_r <= sdram_cmd_pkg::DEV_POWER_DOWN;
          end
        end
        sdram_cmd_pkg::DEV_POWER_DOWN: begin
          if (wake) begin
            state_r <= sdram_cmd_pkg::DEV_RUN;
          end
        end
        sdram_cmd_pkg::DEV_SELF_REFRESH: begin
          if (wake) begin
            state_r <= sdram_cmd_pkg::DEV_RUN;
          end
        end
        default: state_r <= sdram_cmd_pkg::DEV_RUN;
      endcase
    end
  end

  // per-bank open state and row
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      open_r     <= '0;
      auto_pre_r <= '0;
      for (int i = 0; i < N; i++) begin
        row_r[i] <= '0;
      end
    end else if (running && link.clock_gate_in) begin
      auto_pre_r <= '0;
      // auto-precharge closes bank once its access ends
      open_r <= open_r & ~auto_pre_r;
      case (op)
        sdram_cmd_pkg::OP_ACT: begin
          if (!open_r[bank]) begin
            open_r[bank] <= 1'b1;
            row_r[bank]  <= link.addr;
          end
        end
        sdram_cmd_pkg::OP_READ, sdram_cmd_pkg::OP_WRITE: begin
          if (open_r[bank] && link.addr[sdram_cmd_pkg::PRE_BIT]) begin
            auto_pre_r[bank] <= 1'b1;
          end
        end
        sdram_cmd_pkg::OP_PRE: begin
          if (link.addr[sdram_cmd_pkg::PRE_BIT]) begin
            open_r <= '0;
          end else begin
            open_r[bank] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // mode register, loaded only with all banks idle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_r <= '0;
    end else if (running && link.clock_gate_in
                 && op == sdram_cmd_pkg::OP_MRS && open_r == '0) begin
      mode_r <= link.addr;
    end
  end

  // write path with zero-latency byte masks
  always_comb begin
    waddr = mem_index(bank, col);
  end

  always_ff @(posedge core_clk) begin
    if (running && link.clock_gate_in && op == sdram_cmd_pkg::OP_WRITE
        && hit) begin
      if (!link.lower_byte_mask) begin
        mem[waddr][7:0] <= link.data_lines[7:0];
      end
      if (!link.upper_byte_mask) begin
        mem[waddr][15:8] <= link.data_lines[15:8];
      end
    end
  end

  // read pipeline: data and masks delayed two edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_valid_r  <= '0;
      rd_pipe_r[0] <= '0;
      rd_pipe_r[1] <= '0;
      mask_pipe_r[0] <= 2'h3;
      mask_pipe_r[1] <= 2'h3;
    end else if (link.clock_gate_in || !running) begin
      rd_valid_r[0] <= running && op == sdram_cmd_pkg::OP_READ && hit;
      rd_valid_r[1] <= rd_valid_r[0];
      rd_pipe_r[0]  <= mem[mem_index(bank, col)];
      rd_pipe_r[1]  <= rd_pipe_r[0];
      mask_pipe_r[0] <= {link.upper_byte_mask, link.lower_byte_mask};
      mask_pipe_r[1] <= mask_pipe_r[0];
    end
  end

  // output drivers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dout_r <= '0;
      oe_r   <= '0;
    end else begin
      dout_r <= rd_pipe_r[1];
      oe_r   <= rd_valid_r[1] ? ~mask_pipe_r[1] : 2'h0;
    end
  end

  assign link.data_dev_out = dout_r;
  assign link.data_dev_oe  = oe_r;
  assign bank_open = open_r;
  assign mode_word = mode_r;
  assign dev_mode  = (state_r == sdram_cmd_pkg::DEV_POWER_DOWN) ? 2'h1 :
                     (state_r == sdram_cmd_pkg::DEV_SELF_REFRESH) ? 2'h2 :
                     2'h0;
endmodule

// ==== hw/sdram_ctrl.sv ====
// controller end: drives commands from a simple user port
`timescale 1ns/1ns
module sdram_ctrl (
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  sdram_link_if.ctrl                             link,
  input  wire logic                              cmd_valid,
  output logic                                   cmd_ready,
  input  wire logic [2:0]                        cmd_code,
  input  wire logic [sdram_cmd_pkg::BANK_W-1:0]  cmd_bank,
  input  wire logic [sdram_cmd_pkg::ROW_W-1:0]   cmd_addr,
  input  wire logic [1:0]                        cmd_mask,
  input  wire logic [sdram_cmd_pkg::DATA_W-1:0]  cmd_wdata,
  input  wire logic                              gate_req,
  output logic [sdram_cmd_pkg::DATA_W-1:0]       rd_data,
  output logic                                   rd_valid
);
  logic [2:0]  code_r;
  logic        sel_n_r;
  logic        gate_r;
  logic        oe_r;
  logic        busy;
  logic [3:0]  rd_sh_r;
  logic [sdram_cmd_pkg::DATA_W-1:0] wdata_r;
  logic [sdram_cmd_pkg::BANK_W-1:0] bank_r;
  logic [sdram_cmd_pkg::ROW_W-1:0]  addr_r;
  logic [1:0]  mask_r;
  logic [sdram_cmd_pkg::DATA_W-1:0] rd_data_r;
  logic        rd_valid_r;

  // refresh is taken with the gate request low: self-refresh entry
  assign cmd_ready = gate_r &&
                     (gate_req || cmd_code == sdram_cmd_pkg::CMD_REF);

  // command register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      code_r  <= sdram_cmd_pkg::CMD_NOP;
      sel_n_r <= 1'b1;
      bank_r  <= '0;
      addr_r  <= '0;
      mask_r  <= 2'h3;
      wdata_r <= '0;
      oe_r    <= 1'b0;
    end else if (cmd_valid && cmd_ready) begin
      code_r  <= cmd_code;
      sel_n_r <= 1'b0;
      bank_r  <= cmd_bank;
      addr_r  <= cmd_addr;
      mask_r  <= cmd_mask;
      wdata_r <= cmd_wdata;
      oe_r    <= (cmd_code == sdram_cmd_pkg::CMD_WR);
    end else begin
      code_r  <= sdram_cmd_pkg::CMD_NOP;
      sel_n_r <= 1'b1;
      oe_r    <= 1'b0;
    end
  end

  // clock gate; held high while a read is requested or rd_sh_r is nonzero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gate_r <= 1'b1;
    end else if (busy) begin
      gate_r <= 1'b1;
    end else begin
      gate_r <= gate_req;
    end
  end

  // read return, captured three edges after the device samples
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_sh_r    <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      rd_sh_r <= {rd_sh_r[2:0], !sel_n_r && code_r == sdram_cmd_pkg::CMD_RD};
      rd_valid_r <= rd_sh_r[2];
      rd_data_r  <= link.data_lines;
    end
  end

  assign busy = |rd_sh_r || (cmd_valid && cmd_code == sdram_cmd_pkg::CMD_RD);

  assign link.select_n        = sel_n_r;
  assign link.row_strobe_n    = code_r[2];
  assign link.col_strobe_n    = code_r[1];
  assign link.write_strobe_n  = code_r[0];
  assign link.clock_gate_in   = gate_r;
  assign link.bank_sel        = bank_r;
  assign link.addr            = addr_r;
  assign link.lower_byte_mask = mask_r[0];
  assign link.upper_byte_mask = mask_r[1];
  assign link.data_ctl_out    = wdata_r;
  assign link.data_ctl_oe     = oe_r;
  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;
endmodule

// ==== tb/sdram_link_checker.sv ====
// concurrent checks on the controller to device link
`timescale 1ns/1ns
module sdram_link_checker (
  input wire logic                             core_clk,
  input wire logic                             rstn,
  input wire logic                             select_n,
  input wire logic                             row_strobe_n,
  input wire logic                             col_strobe_n,
  input wire logic                             write_strobe_n,
  input wire logic                             clock_gate_in,
  input wire logic [sdram_cmd_pkg::BANK_W-1:0] bank_sel,
  input wire logic [sdram_cmd_pkg::ROW_W-1:0]  addr,
  input wire logic                             upper_byte_mask,
  input wire logic                             data_ctl_oe,
  input wire logic [1:0]                       data_dev_oe,
  input wire logic [3:0]                       bank_open,
  input wire logic [sdram_cmd_pkg::ROW_W-1:0]  mode_word,
  input wire logic [1:0]                       dev_mode
);
  logic       gate_prev_r;
  logic [2:0] code;
  logic       live;
  logic       idle_code;

  always_ff @(posedge core_clk) begin
    gate_prev_r <= clock_gate_in;
  end
  assign code = {row_strobe_n, col_strobe_n, write_strobe_n};
  assign live = !select_n && clock_gate_in && gate_prev_r && dev_mode == 2'h0;
  assign idle_code = select_n || code == sdram_cmd_pkg::CMD_NOP;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_act_opens_bank: assert property (
    live && code == sdram_cmd_pkg::CMD_ACT |=> bank_open[$past(bank_sel)])
    else $error("activate did not open the bank");
  chk_pre_all_banks: assert property (
    live && code == sdram_cmd_pkg::CMD_PRE && addr[sdram_cmd_pkg::PRE_BIT]
    |=> bank_open == 4'h0) else $error("precharge all left a bank open");
  chk_auto_pre_close: assert property (
    live && (code == sdram_cmd_pkg::CMD_RD || code == sdram_cmd_pkg::CMD_WR)
    && addr[sdram_cmd_pkg::PRE_BIT] && bank_open[bank_sel]
    |=> !bank_open[$past(bank_sel)] or ##1 !bank_open[$past(bank_sel, 2)])
    else $error("auto precharge did not close the bank");
  chk_idle_no_effect: assert property (
    idle_code && bank_open == 4'h0 |=> bank_open == 4'h0 && $stable(mode_word))
    else $error("idle edge changed device state");
  chk_mode_load_word: assert property (
    live && code == sdram_cmd_pkg::CMD_MRS && bank_open == 4'h0
    |=> mode_word == $past(addr)) else $error("mode load not stored");
  chk_mode_load_open: assert property (
    live && code == sdram_cmd_pkg::CMD_MRS && bank_open != 4'h0
    |=> $stable(mode_word)) else $error("mode load taken with bank open");
  chk_pd_entry: assert property (
    gate_prev_r && !clock_gate_in && idle_code && dev_mode == 2'h0
    |=> dev_mode == 2'h1) else $error("power-down not entered");
  chk_pd_exit: assert property (
    dev_mode == 2'h1 && clock_gate_in && !gate_prev_r && idle_code
    |=> dev_mode == 2'h0) else $error("power-down not left");
  chk_rd_mask_tristate: assert property (
    data_dev_oe[0] && !data_dev_oe[1] |-> $past(upper_byte_mask, 3))
    else $error("upper byte released without mask");
  chk_sr_entry: assert property (
    gate_prev_r && !clock_gate_in && !select_n
    && code == sdram_cmd_pkg::CMD_REF && bank_open == 4'h0 && dev_mode == 2'h0
    |=> dev_mode == 2'h2) else $error("self refresh not entered");
  chk_wr_data_drive: assert property (
    data_ctl_oe |-> !select_n && code == sdram_cmd_pkg::CMD_WR)
    else $error("write data driven outside a write");

  cov_activate: cover property (live && code == sdram_cmd_pkg::CMD_ACT);
  cov_read: cover property (live && code == sdram_cmd_pkg::CMD_RD);
  cov_power_down: cover property (dev_mode == 2'h1);
  cov_self_refresh: cover property (dev_mode == 2'h2);
endmodule

// ==== tb/sdram_command_interface_tb.sv ====
// self-checking bench for the controller and device pair
`timescale 1ns/1ns
module sdram_command_interface_tb;
  logic        core_clk;
  logic        rstn;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        gate_req;
  logic        rd_valid;
  logic [2:0]  cmd_code;
  logic [1:0]  cmd_bank;
  logic [1:0]  cmd_mask;
  logic [12:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [15:0] rd_data;
  logic [3:0]  bank_open;
  logic [12:0] mode_word;
  logic [1:0]  dev_mode;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;

  sdram_link_if link();
  sdram_ctrl i_sdram_ctrl (.core_clk(core_clk), .rstn(rstn), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_mask(cmd_mask),
    .cmd_wdata(cmd_wdata), .gate_req(gate_req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sdram_device i_sdram_device (.core_clk(core_clk), .rstn(rstn), .link(link),
    .bank_open(bank_open), .mode_word(mode_word), .dev_mode(dev_mode));
  sdram_link_checker i_sdram_link_checker (.core_clk(core_clk), .rstn(rstn),
    .select_n(link.select_n), .row_strobe_n(link.row_strobe_n),
    .col_strobe_n(link.col_strobe_n), .write_strobe_n(link.write_strobe_n),
    .clock_gate_in(link.clock_gate_in), .bank_sel(link.bank_sel),
    .addr(link.addr), .upper_byte_mask(link.upper_byte_mask),
    .data_ctl_oe(link.data_ctl_oe), .data_dev_oe(link.data_dev_oe),
    .bank_open(bank_open), .mode_word(mode_word), .dev_mode(dev_mode));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic issue(input logic [2:0] c, input logic [1:0] b,
                       input logic [12:0] a, input logic [1:0] m,
                       input logic [15:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_bank <= b;
    cmd_addr <= a;
    cmd_mask <= m;
    cmd_wdata <= d;
    #1;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 20) err_total++;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    issue(c, b, a, m, d);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic rd(input logic [1:0] b, input logic [12:0] a,
                    input logic [1:0] m, input logic [15:0] exp);
    int n;
    n = 0;
    issue(sdram_cmd_pkg::CMD_RD, b, a, m, 16'h0000);
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (rd_valid !== 1'b1 && n < 10);
    check("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    check("rd_data", rd_data, exp);
    @(posedge core_clk);
    #1;
    check("rd_valid", {15'h0000, rd_valid}, 16'h0000);
  endtask

  initial begin
    rstn = 1'b0;
    gate_req = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = sdram_cmd_pkg::CMD_NOP;
    cmd_bank = 2'h0;
    cmd_addr = 13'h0000;
    cmd_mask = 2'h0;
    cmd_wdata = 16'h0000;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("bank_open", {12'h000, bank_open}, 16'h0000);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0000);
    cmd(sdram_cmd_pkg::CMD_MRS, 2'h0, 13'h0123, 2'h0, 16'h0000);
    check("mode_word", {3'h0, mode_word}, 16'h0123);
    cmd(sdram_cmd_pkg::CMD_ACT, 2'h1, 13'h1ABC, 2'h0, 16'h0000);
    cmd(sdram_cmd_pkg::CMD_ACT, 2'h2, 13'h0007, 2'h0, 16'h0000);
    check("bank_open", {12'h000, bank_open}, 16'h0006);
    cmd(sdram_cmd_pkg::CMD_MRS, 2'h0, 13'h0456, 2'h0, 16'h0000);
    check("mode_word", {3'h0, mode_word}, 16'h0123);
    cmd(sdram_cmd_pkg::CMD_WR, 2'h1, 13'h0003, 2'h0, 16'hA55A);
    cmd(sdram_cmd_pkg::CMD_WR, 2'h1, 13'h0005, 2'h0, 16'hFFFF);
    cmd(sdram_cmd_pkg::CMD_WR, 2'h1, 13'h0005, 2'h1, 16'h1234);
    rd(2'h1, 13'h1803, 2'h0, 16'hA55A);
    rd(2'h1, 13'h0003, 2'h1, 16'hA500);
    rd(2'h1, 13'h0005, 2'h2, 16'h00FF);
    cmd(sdram_cmd_pkg::CMD_WR, 2'h2, 13'h0400, 2'h0, 16'h5A5A);
    check("bank_open", {12'h000, bank_open}, 16'h0002);
    gate_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0001);
    gate_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0000);
    check("bank_open", {12'h000, bank_open}, 16'h0002);
    cmd(sdram_cmd_pkg::CMD_PRE, 2'h1, 13'h0000, 2'h0, 16'h0000);
    check("bank_open", {12'h000, bank_open}, 16'h0000);
    cmd(sdram_cmd_pkg::CMD_ACT, 2'h0, 13'h0011, 2'h0, 16'h0000);
    cmd(sdram_cmd_pkg::CMD_ACT, 2'h3, 13'h0022, 2'h0, 16'h0000);
    check("bank_open", {12'h000, bank_open}, 16'h0009);
    cmd(sdram_cmd_pkg::CMD_WR, 2'h1, 13'h0003, 2'h0, 16'h1111);
    cmd(sdram_cmd_pkg::CMD_ACT, 2'h1, 13'h0001, 2'h0, 16'h0000);
    rd(2'h1, 13'h0003, 2'h0, 16'hA55A);
    check("bank_open", {12'h000, bank_open}, 16'h000B);
    cmd(sdram_cmd_pkg::CMD_PRE, 2'h1, 13'h0400, 2'h0, 16'h0000);
    check("bank_open", {12'h000, bank_open}, 16'h0000);
    cmd(sdram_cmd_pkg::CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0000);
    gate_req <= 1'b0;
    cmd(sdram_cmd_pkg::CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0002);
    gate_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("dev_mode", {14'h0000, dev_mode}, 16'h0000);
    conclude();
  end
endmodule
